// *** logic/mc_pkg.sv ***
// Purpose: Constants and types of the motor mode and status control block
// Assumes: 16-bit register words, 12-bit analog samples
// Notes:   Register addresses are the printed word addresses
package mc_pkg;
    // ==========================================
    // Register addresses
    localparam logic [15:0] MC_A_SHORT_CLR  = 16'h4000;
    localparam logic [15:0] MC_A_LOOP_EN    = 16'h4001;
    localparam logic [15:0] MC_A_SRC_SEL    = 16'h4002;
    localparam logic [15:0] MC_A_BRAKE_SEL  = 16'h4003;
    localparam logic [15:0] MC_A_ACCEL      = 16'h3000;
    localparam logic [15:0] MC_A_DECEL      = 16'h3001;
    localparam logic [15:0] MC_A_SP_CLOSED  = 16'h3002;
    localparam logic [15:0] MC_A_SP_OPEN    = 16'h3003;
    localparam logic [15:0] MC_A_ILIM_MODE  = 16'h300E;
    localparam logic [15:0] MC_A_ILIM_VAL   = 16'h1002;
    localparam logic [15:0] MC_A_BEMF_TGT   = 16'h1003;
    localparam logic [15:0] MC_A_BEMF_ACT   = 16'h1004;
    localparam logic [15:0] MC_A_PWM_TGT    = 16'h1006;
    localparam logic [15:0] MC_A_PWM_ACT    = 16'h1007;
    localparam logic [15:0] MC_A_STATUS     = 16'h1000;
    // ==========================================
    // Reset values and encodings
    localparam logic [15:0] MC_RST_ACCEL    = 16'h0010;
    localparam logic [15:0] MC_RST_DECEL    = 16'h0010;
    localparam logic [1:0]  MC_ILIM_OFF     = 2'h0;
    localparam logic [1:0]  MC_ILIM_HW      = 2'h1;
    localparam logic [1:0]  MC_ILIM_SWHW    = 2'h2;
    localparam logic [11:0] MC_KNOB_STOP    = 12'h010;
    // ==========================================
    // Timing
    localparam int MC_CLK_HZ    = 100_000_000;
    localparam int MC_BLINK_HZ  = 2;
    localparam int MC_BLINK_CYC = MC_CLK_HZ / (2 * MC_BLINK_HZ);
    localparam int MC_RAMP_US   = 100;
    localparam int MC_RAMP_CYC  = MC_RAMP_US * (MC_CLK_HZ / 1_000_000);
    // ==========================================
    // Types
    typedef struct packed {
        logic [11:0] knob;
        logic [11:0] trim_lo;
        logic [11:0] trim_hi;
        logic [11:0] trim_ilim;
        logic [11:0] current;
        logic [11:0] bemf;
    } mc_meas_t;
    typedef struct packed {
        logic short_det;
        logic over_cur;
        logic hw_peak_lim;
    } mc_flags_t;
    typedef struct packed {
        logic red;
        logic green;
    } mc_led_t;
    typedef enum logic [2:0] {
        MC_ST_RUN   = 3'b001,
        MC_ST_STOP  = 3'b010,
        MC_ST_FAULT = 3'b100
    } mc_state_t;
endpackage

// *** logic/mc_ctrl.sv ***
// Purpose: Mode control and status indication of a brush DC motor controller
// Assumes: Analog samples and fault pins are asynchronous and synchronised here
// Notes:   Register port is a word-addressed read/write strobe interface
// How it works
// - Short clear works only once cause gone
// - Loop enable one: closed-loop BEMF stabilisation
// - Loop enable zero: open-loop setpoint
// - Source select picks register or knob
// - Brake select shorts terminals in stop
// - Knob at CCW end forces stop
// - Short or overcurrent: drive off, fault
// - Latched short fault: steady red
// - Current limiting: blinking green plus red
// - Nonzero PWM, no fault: blinking green
// - Zero PWM, no fault: steady green
// - Limit mode register, trimmer value readback
// - Ramp with accel and decel rates
// - Knob spans low to high trim
// - Ready after power: LED lit steadily
// - Limit mode 0 off, 1 hw, 2 both
module mc_ctrl
    import mc_pkg::*;
#(
    parameter int BLINK_CYC = MC_BLINK_CYC,
    parameter int RAMP_CYC  = MC_RAMP_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    output logic             o_reg_ack,
    input  wire mc_meas_t    i_meas,
    input  wire mc_flags_t   i_flags,
    output logic      [11:0] o_pwm,
    output logic             o_drive_en,
    output logic             o_brake_short,
    output logic             o_forced_stop,
    output logic             o_fault,
    output mc_led_t          o_led
);
    // ==========================================
    // Input synchronisers
    mc_meas_t  meas_s1_q, meas_q;
    mc_flags_t flg_s1_q, flg_q;
    always_ff @(posedge i_clk) begin
        meas_s1_q <= i_meas;
        meas_q    <= meas_s1_q;
        flg_s1_q  <= i_flags;
        flg_q     <= flg_s1_q;
    end

    function automatic logic [11:0] step_to(input logic [11:0] cur, input logic [11:0] tgt,
                                            input logic [15:0] up, input logic [15:0] dn);
        logic [12:0] s;
        s = 13'h0000;
        if (tgt > cur) begin
            s = {1'b0, cur} + {1'b0, (up[15:12] != 4'h0) ? 12'hFFF : up[11:0]};
            step_to = (s > {1'b0, tgt}) ? tgt : s[11:0];
        end else begin
            s = {1'b0, cur} - {1'b0, (dn[15:12] != 4'h0) ? 12'hFFF : dn[11:0]};
            step_to = (s[12] || s[11:0] < tgt) ? tgt : s[11:0];
        end
    endfunction

    // ==========================================
    // State
    mc_state_t   st_q, st_d;
    logic        loop_en_q, loop_en_d, src_sel_q, src_sel_d, brk_q, brk_d;
    logic        short_q, short_d, ready_q, ready_d, blink_q, blink_d;
    logic [15:0] accel_q, accel_d, decel_q, decel_d, spc_q, spc_d, spo_q, spo_d;
    logic [1:0]  ilim_q, ilim_d;
    logic [11:0] pwm_q, pwm_d, ptgt_q, ptgt_d, btgt_q, btgt_d;
    logic [31:0] bcnt_q, bcnt_d, rcnt_q, rcnt_d;
    logic [15:0] rdata_q, rdata_d;
    logic        ack_q, ack_d;
    logic [23:0] span;
    logic [11:0] knob_sp, sp;
    logic        tick, stop_req, sw_lim, lim_act, clr_req;

    always_comb begin
        span     = 24'h000000;
        knob_sp  = 12'h000;
        sp       = 12'h000;
        st_d     = st_q;
        loop_en_d = loop_en_q;
        src_sel_d = src_sel_q;
        brk_d    = brk_q;
        accel_d  = accel_q;
        decel_d  = decel_q;
        spc_d    = spc_q;
        spo_d    = spo_q;
        ilim_d   = ilim_q;
        ready_d  = 1'b1;
        rdata_d  = 16'h0000;
        ack_d    = i_reg_wr | i_reg_rd;
        clr_req  = 1'b0;
        // Knob mapped between the speed trims
        if (meas_q.trim_hi > meas_q.trim_lo) begin
            span = 24'((meas_q.trim_hi - meas_q.trim_lo) * meas_q.knob);
        end
        knob_sp  = meas_q.trim_lo + span[23:12];
        stop_req = meas_q.knob <= MC_KNOB_STOP;
        // Setpoint source and loop mode
        if (src_sel_q) begin
            sp = loop_en_q ? spc_q[11:0] : spo_q[11:0];
        end else begin
            sp = knob_sp;
        end
        sw_lim  = (ilim_q == MC_ILIM_SWHW) && (meas_q.current > meas_q.trim_ilim);
        lim_act = ((ilim_q == MC_ILIM_HW || ilim_q == MC_ILIM_SWHW) && flg_q.hw_peak_lim) || sw_lim;
        // Register writes
        if (i_reg_wr) begin
            case (i_reg_addr)
                MC_A_SHORT_CLR: clr_req = i_reg_wdata[0];
                MC_A_LOOP_EN:   loop_en_d = i_reg_wdata[0];
                MC_A_SRC_SEL:   src_sel_d = i_reg_wdata[0];
                MC_A_BRAKE_SEL: brk_d = i_reg_wdata[0];
                MC_A_ACCEL:     accel_d = i_reg_wdata;
                MC_A_DECEL:     decel_d = i_reg_wdata;
                MC_A_SP_CLOSED: spc_d = i_reg_wdata;
                MC_A_SP_OPEN:   spo_d = i_reg_wdata;
                MC_A_ILIM_MODE: ilim_d = i_reg_wdata[1:0];
                default: ;
            endcase
        end
        // Register reads
        if (i_reg_rd) begin
            case (i_reg_addr)
                MC_A_LOOP_EN:   rdata_d = {15'h0000, loop_en_q};
                MC_A_SRC_SEL:   rdata_d = {15'h0000, src_sel_q};
                MC_A_BRAKE_SEL: rdata_d = {15'h0000, brk_q};
                MC_A_ACCEL:     rdata_d = accel_q;
                MC_A_DECEL:     rdata_d = decel_q;
                MC_A_SP_CLOSED: rdata_d = spc_q;
                MC_A_SP_OPEN:   rdata_d = spo_q;
                MC_A_ILIM_MODE: rdata_d = {14'h0000, ilim_q};
                MC_A_ILIM_VAL:  rdata_d = {4'h0, meas_q.trim_ilim};
                MC_A_BEMF_TGT:  rdata_d = {4'h0, btgt_q};
                MC_A_BEMF_ACT:  rdata_d = {4'h0, meas_q.bemf};
                MC_A_PWM_TGT:   rdata_d = {4'h0, ptgt_q};
                MC_A_PWM_ACT:   rdata_d = {4'h0, pwm_q};
                MC_A_STATUS:    rdata_d = {11'h000, lim_act, short_q, st_q};
                default:        rdata_d = 16'h0000;
            endcase
        end
        // Short fault latch: set wins over clear
        short_d = short_q;
        if (clr_req && !flg_q.short_det) begin
            short_d = 1'b0;
        end
        if (flg_q.short_det) begin
            short_d = 1'b1;
        end
        // Mode sequencing
        case (st_q)
            MC_ST_RUN: begin
                if (flg_q.short_det || flg_q.over_cur) begin
                    st_d = MC_ST_FAULT;
                end else if (stop_req) begin
                    st_d = MC_ST_STOP;
                end
            end
            MC_ST_STOP: begin
                if (flg_q.short_det || flg_q.over_cur) begin
                    st_d = MC_ST_FAULT;
                end else if (!stop_req) begin
                    st_d = MC_ST_RUN;
                end
            end
            MC_ST_FAULT: begin
                if (!short_d && !flg_q.over_cur) begin
                    st_d = stop_req ? MC_ST_STOP : MC_ST_RUN;
                end
            end
            default: st_d = MC_ST_FAULT;
        endcase
        // Ramp tick
        tick   = rcnt_q >= 32'(RAMP_CYC - 1);
        rcnt_d = tick ? 32'h00000000 : rcnt_q + 32'h00000001;
        // Target PWM: open loop direct, closed loop trims on BEMF error
        btgt_d = loop_en_q ? sp : 12'h000;
        ptgt_d = ptgt_q;
        if (!loop_en_q) begin
            ptgt_d = sp;
        end else if (tick) begin
            if (meas_q.bemf < btgt_q && ptgt_q != 12'hFFF) begin
                ptgt_d = ptgt_q + 12'h001;
            end else if (meas_q.bemf > btgt_q && ptgt_q != 12'h000) begin
                ptgt_d = ptgt_q - 12'h001;
            end
        end
        // Actual PWM ramp
        pwm_d = pwm_q;
        if (st_q != MC_ST_RUN) begin
            pwm_d  = 12'h000;
            ptgt_d = loop_en_q ? 12'h000 : ptgt_d;
        end else if (tick) begin
            if (sw_lim) begin
                pwm_d = step_to(pwm_q, 12'h000, accel_q, 16'h0001);
            end else begin
                pwm_d = step_to(pwm_q, ptgt_q, accel_q, decel_q);
            end
        end
        // Blink timebase
        blink_d = blink_q;
        bcnt_d  = bcnt_q + 32'h00000001;
        if (bcnt_q >= 32'(BLINK_CYC - 1)) begin
            bcnt_d  = 32'h00000000;
            blink_d = !blink_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q      <= MC_ST_STOP;
            loop_en_q <= 1'b0;
            src_sel_q <= 1'b0;
            brk_q     <= 1'b0;
            short_q   <= 1'b0;
            ready_q   <= 1'b0;
            blink_q   <= 1'b0;
            accel_q   <= MC_RST_ACCEL;
            decel_q   <= MC_RST_DECEL;
            spc_q     <= 16'h0000;
            spo_q     <= 16'h0000;
            ilim_q    <= MC_ILIM_OFF;
            pwm_q     <= 12'h000;
            ptgt_q    <= 12'h000;
            btgt_q    <= 12'h000;
            bcnt_q    <= 32'h00000000;
            rcnt_q    <= 32'h00000000;
            rdata_q   <= 16'h0000;
            ack_q     <= 1'b0;
        end else begin
            st_q      <= st_d;
            loop_en_q <= loop_en_d;
            src_sel_q <= src_sel_d;
            brk_q     <= brk_d;
            short_q   <= short_d;
            ready_q   <= ready_d;
            blink_q   <= blink_d;
            accel_q   <= accel_d;
            decel_q   <= decel_d;
            spc_q     <= spc_d;
            spo_q     <= spo_d;
            ilim_q    <= ilim_d;
            pwm_q     <= pwm_d;
            ptgt_q    <= ptgt_d;
            btgt_q    <= btgt_d;
            bcnt_q    <= bcnt_d;
            rcnt_q    <= rcnt_d;
            rdata_q   <= rdata_d;
            ack_q     <= ack_d;
        end
    end

    // ==========================================
    // LED and drive outputs
    mc_led_t led_d, led_q;
    always_comb begin
        led_d = '{red: 1'b0, green: 1'b0};
        if (!ready_q) begin
            led_d = '{red: 1'b0, green: 1'b0};
        end else if (short_q || st_q == MC_ST_FAULT) begin
            led_d = '{red: 1'b1, green: 1'b0};
        end else if (lim_act) begin
            led_d = '{red: 1'b1, green: blink_q};
        end else if (pwm_q != 12'h000) begin
            led_d = '{red: 1'b0, green: blink_q};
        end else begin
            led_d = '{red: 1'b0, green: 1'b1};
        end
    end

    logic drv_q, drv_d, brs_q, brs_d;
    always_comb begin
        drv_d = (st_q == MC_ST_RUN) && !short_q;
        brs_d = (st_q == MC_ST_STOP) && brk_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            led_q <= '{red: 1'b0, green: 1'b0};
            drv_q <= 1'b0;
            brs_q <= 1'b0;
        end else begin
            led_q <= led_d;
            drv_q <= drv_d;
            brs_q <= brs_d;
        end
    end

    assign o_led         = led_q;
    assign o_drive_en    = drv_q;
    assign o_brake_short = brs_q;
    assign o_pwm         = pwm_q;
    assign o_forced_stop = st_q == MC_ST_STOP;
    assign o_fault       = st_q == MC_ST_FAULT;
    assign o_reg_rdata   = rdata_q;
    assign o_reg_ack     = ack_q;
endmodule

// *** tb/mc_ctrl_assertions.sv ***
// Purpose: Port checks of the motor mode and status control block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every mc_ctrl instance
module mc_ctrl_chk
    import mc_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        o_reg_ack,
    input wire mc_meas_t    i_meas,
    input wire mc_flags_t   i_flags,
    input wire logic [11:0] o_pwm,
    input wire logic        o_drive_en,
    input wire logic        o_brake_short,
    input wire logic        o_forced_stop,
    input wire logic        o_fault,
    input wire mc_led_t     o_led
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====
    // Properties
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    property p_ack; o_reg_ack == $past(i_reg_wr || i_reg_rd); endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_rdz; !$past(i_reg_rd) |-> o_reg_rdata == 16'h0000; endproperty
    a_rdz: assert property (p_rdz) else $error("read data not zero");
    property p_stop; (i_meas.knob <= MC_KNOB_STOP) [*4] |-> (o_forced_stop || o_fault); endproperty
    a_stop: assert property (p_stop) else $error("knob end without stop");
    property p_brake; o_brake_short |-> $past(o_forced_stop); endproperty
    a_brake: assert property (p_brake) else $error("brake outside stop");
    property p_short; i_flags.short_det [*4] |-> o_fault; endproperty
    a_short: assert property (p_short) else $error("short without fault");
    property p_hold; (o_fault && i_flags.short_det) [*3] |=> o_fault; endproperty
    a_hold: assert property (p_hold) else $error("fault left with short present");
    property p_off; o_fault && $past(o_fault) |-> !o_drive_en && o_pwm == 12'h000; endproperty
    a_off: assert property (p_off) else $error("drive on in fault");
    property p_red; o_fault && $past(o_fault) |-> o_led.red; endproperty
    a_red: assert property (p_red) else $error("red off in fault");
    property p_idle; (!o_fault && !o_led.red && o_pwm == 12'h000) [*3] |-> o_led.green; endproperty
    a_idle: assert property (p_idle) else $error("green off while stopped");
    c_fault: cover property (o_fault ##1 !o_fault);
    c_brake: cover property (o_brake_short);
    c_lim: cover property (o_led.red && !o_fault);
endmodule
bind mc_ctrl mc_ctrl_chk i_mc_ctrl_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_reg_ack(o_reg_ack), .i_meas(i_meas), .i_flags(i_flags), .o_pwm(o_pwm), .o_drive_en(o_drive_en),
    .o_brake_short(o_brake_short), .o_forced_stop(o_forced_stop), .o_fault(o_fault), .o_led(o_led)
);

// *** tb/mc_host.sv ***
// Purpose: Host model issuing register accesses
// Assumes: One-cycle strobes, ack registered on the taking edge
// Notes:   Idle address and data lines show the inverse of the last value
module mc_host (
    input  wire logic        i_clk,
    input  wire logic        i_ack,
    input  wire logic [15:0] i_rdata,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [15:0] o_addr,
    output logic      [15:0] o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 16'h0000;
    end
    // ====
    // One access
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
        int n;
        @(posedge i_clk) #1;
        o_wr = w;
        o_rd = !w;
        o_addr = a;
        o_wdata = d;
        @(posedge i_clk) #1;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
        q = 16'hXXXX;
        for (n = 0; n < 4 && i_ack !== 1'b1; n++) @(posedge i_clk) #1;
        if (i_ack === 1'b1) q = i_rdata;
    endtask
endmodule

// *** tb/testbench.sv ***
// Purpose: Self-checking bench of the motor mode and status control block
// Assumes: Host model drives registers, bench drives the motor side
// Notes:   Short blink and ramp periods
module testbench
    import mc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, wr, rd, ack, drive_en, brake_short, forced_stop, fault;
    logic [15:0] addr, wdata, rdata;
    logic [11:0] pwm;
    mc_meas_t    meas;
    mc_flags_t   flags;
    mc_led_t     led;
    int          errors = 0, n_tests = 0, tg, on, n;
    mc_ctrl #(.BLINK_CYC(8), .RAMP_CYC(4)) i_mc_ctrl (
        .i_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_ack(ack), .i_meas(meas), .i_flags(flags), .o_pwm(pwm),
        .o_drive_en(drive_en), .o_brake_short(brake_short), .o_forced_stop(forced_stop), .o_fault(fault),
        .o_led(led)
    );
    mc_host i_mc_host (.i_clk(clk), .i_ack(ack), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata));
    // ====
    // Tasks
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk1(input string nm, input logic got, input logic exp);
        chk(nm, {15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] q;
        i_mc_host.access(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [15:0] a, input logic [15:0] e);
        logic [15:0] q;
        i_mc_host.access(1'b0, a, 16'h0000, q);
        chk(nm, q, e);
    endtask
    task automatic watch();
        logic g;
        tg = 0;
        on = 0;
        g = led.green;
        repeat (40) begin
            cyc(1);
            tg += (led.green !== g);
            on += (led.green === 1'b1);
            g = led.green;
        end
    endtask
    // ====
    // Clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        flags = '0;
        meas = '0;
        meas.trim_lo = 12'h100;
        meas.trim_hi = 12'h300;
        meas.trim_ilim = 12'h0AB;
        cyc(8);
        rst = 1'b0;
        cyc(4);
        rd_chk("status", MC_A_STATUS, 16'h0002);
        watch();
        chk1("steady green", on == 40, 1'b1);
        chk1("red idle", led.red, 1'b0);
        rd_chk("accel", MC_A_ACCEL, MC_RST_ACCEL);
        rd_chk("decel", MC_A_DECEL, MC_RST_DECEL);
        for (n = 0; n < 3; n++) begin
            wr_reg(MC_A_ILIM_MODE, 16'(n));
            rd_chk("limit mode", MC_A_ILIM_MODE, 16'(n));
        end
        for (n = 1; n < 4; n++) begin
            wr_reg(MC_A_SHORT_CLR + 16'(n), 16'h0001);
            rd_chk("coil", MC_A_SHORT_CLR + 16'(n), 16'h0001);
        end
        rd_chk("clear coil", MC_A_SHORT_CLR, 16'h0000);
        rd_chk("unmapped", 16'h5A5A, 16'h0000);
        wr_reg(MC_A_ILIM_VAL, 16'hFFFF);
        rd_chk("trim", MC_A_ILIM_VAL, 16'h00AB);
        wr_reg(MC_A_ILIM_MODE, 16'h0000);
        wr_reg(MC_A_LOOP_EN, 16'h0000);
        wr_reg(MC_A_SP_OPEN, 16'h0040);
        wr_reg(MC_A_SP_CLOSED, 16'h0123);
        meas.knob = 12'h800;
        cyc(100);
        rd_chk("open pwm", MC_A_PWM_ACT, 16'h0040);
        watch();
        chk1("blink", tg > 1, 1'b1);
        chk("blink period", 16'(tg), 16'h0005);
        wr_reg(MC_A_SRC_SEL, 16'h0000);
        cyc(200);
        chk("knob pwm", {4'h0, pwm}, 16'h0200);
        wr_reg(MC_A_DECEL, 16'h0008);
        wr_reg(MC_A_SP_OPEN, 16'h01F0);
        wr_reg(MC_A_SRC_SEL, 16'h0001);
        for (n = 0; n < 20 && pwm === 12'h200; n++) cyc(1);
        chk("decel step", {4'h0, pwm}, 16'h01F8);
        wr_reg(MC_A_LOOP_EN, 16'h0001);
        cyc(4);
        rd_chk("bemf target", MC_A_BEMF_TGT, 16'h0123);
        wr_reg(MC_A_LOOP_EN, 16'h0000);
        flags.hw_peak_lim = 1'b1;
        cyc(6);
        chk1("red limit off", led.red, 1'b0);
        wr_reg(MC_A_ILIM_MODE, 16'h0001);
        cyc(6);
        chk1("red limit", led.red, 1'b1);
        rd_chk("limit status", MC_A_STATUS, 16'h0011);
        watch();
        chk1("blink limit", tg > 1, 1'b1);
        flags.hw_peak_lim = 1'b0;
        wr_reg(MC_A_ILIM_MODE, 16'h0002);
        meas.current = 12'h0FF;
        cyc(6);
        chk1("soft limit", led.red, 1'b1);
        rd_chk("soft status", MC_A_STATUS, 16'h0011);
        meas.current = 12'h000;
        cyc(6);
        chk1("soft limit off", led.red, 1'b0);
        wr_reg(MC_A_BRAKE_SEL, 16'h0001);
        meas.knob = 12'h008;
        cyc(6);
        chk1("stop", forced_stop, 1'b1);
        chk1("brake", brake_short, 1'b1);
        wr_reg(MC_A_BRAKE_SEL, 16'h0000);
        cyc(4);
        chk1("no brake", brake_short, 1'b0);
        meas.knob = 12'h800;
        flags.short_det = 1'b1;
        cyc(6);
        chk1("fault", fault, 1'b1);
        chk1("drive off", drive_en, 1'b0);
        chk("fault led", {14'h0000, led}, 16'h0002);
        wr_reg(MC_A_SHORT_CLR, 16'h0001);
        cyc(4);
        rd_chk("clear refused", MC_A_STATUS, 16'h000C);
        flags.short_det = 1'b0;
        cyc(6);
        rd_chk("latched", MC_A_STATUS, 16'h000C);
        wr_reg(MC_A_SHORT_CLR, 16'h0001);
        cyc(4);
        chk1("cleared", fault, 1'b0);
        flags.over_cur = 1'b1;
        cyc(6);
        chk1("overcurrent", fault, 1'b1);
        flags.over_cur = 1'b0;
        cyc(6);
        chk1("overcurrent gone", fault, 1'b0);
        chk1("drive on", drive_en, 1'b1);
        tally_and_finish();
    end
endmodule
